// *** src/clock_alarm_live_status.sv ***
`timescale 1ns/1ps
module clock_alarm_live_status
  import alarm_status_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Loss-of-signal detectors
  input wire logic input1_signal_lost,
  input wire logic input2_signal_lost,
  input wire logic input3_signal_lost,
  input wire logic input4_signal_lost,
  input wire logic reference_signal_lost,
  // Frequency monitors, lock detector and hold filter
  input wire logic input1_freq_offset,
  input wire logic input2_freq_offset,
  input wire logic input3_freq_offset,
  input wire logic input4_freq_offset,
  input wire logic pll_unlocked,
  input wire logic hold_filter_valid,
  // Control port register access
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd_en,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wdata,
  output alarm_status_pkg::status_byte_t reg_rdata,
  output logic reg_rd_valid,
  // Live register images
  output alarm_status_pkg::status_byte_t input_loss_status,
  output alarm_status_pkg::status_byte_t freq_lock_hold_status
);

  // ------------------------------------------------------------
  // Field packing
  // ------------------------------------------------------------
  function automatic status_byte_t pack_input_loss(input alarm_vec_t a);
    status_byte_t b;
    b = STATUS_RESET;
    b[LOSS_REF_BIT] = a[AL_REF_LOST];
    b[LOSS_INPUT_LSB +: 4] = a[AL_INPUT_LOST_LSB +: 4];
    return b;
  endfunction

  function automatic status_byte_t pack_freq_lock(input alarm_vec_t a);
    status_byte_t b;
    b = STATUS_RESET;
    b[FREQ_UNLOCK_BIT] = a[AL_UNLOCKED];
    b[FREQ_OFFSET_LSB +: 4] = a[AL_FREQ_OFFSET_LSB +: 4];
    b[HOLD_VALID_BIT] = a[AL_HOLD_VALID];
    return b;
  endfunction

  // ------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------
  logic rst_meta;
  logic rst_n_sync;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_n_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n_sync <= rst_meta;
    end
  end

  // ------------------------------------------------------------
  // Alarm synchronisation
  // ------------------------------------------------------------
  alarm_sync_if alarm_bus ();

  assign alarm_bus.raw = {hold_filter_valid, pll_unlocked,
                          input4_freq_offset, input3_freq_offset, input2_freq_offset, input1_freq_offset,
                          input4_signal_lost, input3_signal_lost, input2_signal_lost, input1_signal_lost,
                          reference_signal_lost};

  alarm_sync u_alarm_sync (
    .clk_sys(clk_sys),
    .rst_n_sync(rst_n_sync),
    .alarms(alarm_bus.sync_side)
  );

  // ------------------------------------------------------------
  // Live status images
  // ------------------------------------------------------------
  status_byte_t next_input_loss;
  status_byte_t next_freq_lock;

  assign next_input_loss = pack_input_loss(alarm_bus.synced);
  assign next_freq_lock = pack_freq_lock(alarm_bus.synced);

  always_ff @(posedge clk_sys or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      input_loss_status <= STATUS_RESET;
      freq_lock_hold_status <= STATUS_RESET;
    end else begin
      input_loss_status <= next_input_loss;
      freq_lock_hold_status <= next_freq_lock;
    end
  end

  // ------------------------------------------------------------
  // Register read port; writes have no effect
  // ------------------------------------------------------------
  logic hit_input_loss;
  logic hit_freq_lock;
  status_byte_t next_rdata;

  assign hit_input_loss = (reg_addr == ADDR_INPUT_LOSS);
  assign hit_freq_lock = (reg_addr == ADDR_FREQ_LOCK);
  assign next_rdata = hit_input_loss ? input_loss_status :
                      hit_freq_lock ? freq_lock_hold_status : UNMAPPED_READ;

  always_ff @(posedge clk_sys or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      reg_rdata <= STATUS_RESET;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd_en;
      if (reg_rd_en) begin
        reg_rdata <= next_rdata;
      end
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  logic [1:0] warmup;
  logic settled;

  always_ff @(posedge clk_sys or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      warmup <= 2'h0;
    end else if (warmup != WARMUP_DONE) begin
      warmup <= warmup + 2'h1;
    end
  end

  assign settled = (warmup == WARMUP_DONE);

  a_loss_inputs_live: assert property (@(posedge clk_sys) disable iff (!rst_n_sync)
    settled |-> input_loss_status[4:1] ==
      $past({input4_signal_lost, input3_signal_lost, input2_signal_lost, input1_signal_lost}, 3))
    else $error("input loss bits do not follow the detectors");

  a_loss_ref_live: assert property (@(posedge clk_sys) disable iff (!rst_n_sync)
    settled |-> input_loss_status[0] == $past(reference_signal_lost, 3))
    else $error("reference loss bit does not follow its detector");

  a_freq_offset_live: assert property (@(posedge clk_sys) disable iff (!rst_n_sync)
    settled |-> freq_lock_hold_status[4:1] ==
      $past({input4_freq_offset, input3_freq_offset, input2_freq_offset, input1_freq_offset}, 3))
    else $error("frequency offset bits do not follow the monitors");

  a_unlock_follows: assert property (@(posedge clk_sys) disable iff (!rst_n_sync)
    settled && $rose(pll_unlocked) |-> ##3 freq_lock_hold_status[0] ##1 1'b1)
    else $error("unlock bit did not rise three cycles after loss of lock");

  a_lock_clears: assert property (@(posedge clk_sys) disable iff (!rst_n_sync)
    settled && $fell(pll_unlocked) |-> ##3 !freq_lock_hold_status[0])
    else $error("unlock bit did not clear three cycles after lock");

  a_hold_valid_live: assert property (@(posedge clk_sys) disable iff (!rst_n_sync)
    settled |-> freq_lock_hold_status[6] == $past(hold_filter_valid, 3))
    else $error("hold valid bit does not follow the hold filter");

  a_reserved_zero: assert property (@(posedge clk_sys) disable iff (!rst_n_sync)
    input_loss_status[7:5] == 3'h0 && freq_lock_hold_status[7] == 1'b0 && freq_lock_hold_status[5] == 1'b0)
    else $error("reserved status bit reads nonzero");

  a_read_returns_image: assert property (@(posedge clk_sys) disable iff (!rst_n_sync)
    reg_rd_en && (reg_addr == ADDR_FREQ_LOCK) |=> reg_rd_valid && reg_rdata == $past(freq_lock_hold_status))
    else $error("read of frequency and lock register returned wrong data");

  a_read_loss_image: assert property (@(posedge clk_sys) disable iff (!rst_n_sync)
    reg_rd_en && (reg_addr == ADDR_INPUT_LOSS) |=> reg_rd_valid && reg_rdata == $past(input_loss_status))
    else $error("read of input loss register returned wrong data");

  a_write_ignored: assert property (@(posedge clk_sys) disable iff (!rst_n_sync)
    reg_wr_en && !reg_rd_en |=> !reg_rd_valid && $stable(reg_rdata))
    else $error("write disturbed the read port");

  a_unmapped_zero: assert property (@(posedge clk_sys) disable iff (!rst_n_sync)
    reg_rd_en && !hit_input_loss && !hit_freq_lock |=> reg_rdata == UNMAPPED_READ)
    else $error("unmapped read returned nonzero");

  a_valid_follows_read: assert property (@(posedge clk_sys) disable iff (!rst_n_sync)
    reg_rd_valid == $past(reg_rd_en))
    else $error("read valid is not a one-cycle echo of the read strobe");

  a_rdata_holds: assert property (@(posedge clk_sys) disable iff (!rst_n_sync)
    !reg_rd_en |=> $stable(reg_rdata))
    else $error("read data changed without a read");

  a_images_clear_reset: assert property (@(posedge clk_sys)
    !rst_n_sync |-> input_loss_status == STATUS_RESET && freq_lock_hold_status == STATUS_RESET)
    else $error("status images not cleared during reset");

  c_read_loss: cover property (@(posedge clk_sys) disable iff (!rst_n_sync)
    reg_rd_en && hit_input_loss ##1 reg_rdata != STATUS_RESET);

  c_read_freq: cover property (@(posedge clk_sys) disable iff (!rst_n_sync)
    reg_rd_en && hit_freq_lock ##1 reg_rdata[HOLD_VALID_BIT]);

  c_unlock_rise: cover property (@(posedge clk_sys) disable iff (!rst_n_sync)
    $rose(freq_lock_hold_status[0]));

  c_back_to_back: cover property (@(posedge clk_sys) disable iff (!rst_n_sync)
    reg_rd_en [*2]);

endmodule

// *** src/alarm_status_pkg.sv ***
package alarm_status_pkg;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_INPUT_LOSS = 8'h81;
  localparam logic [7:0] ADDR_FREQ_LOCK = 8'h82;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int LOSS_REF_BIT = 0;
  localparam int LOSS_INPUT_LSB = 1;
  localparam int FREQ_UNLOCK_BIT = 0;
  localparam int FREQ_OFFSET_LSB = 1;
  localparam int HOLD_VALID_BIT = 6;

  // ------------------------------------------------------------
  // Alarm vector layout between the synchroniser and the registers
  // ------------------------------------------------------------
  localparam int ALARM_W = 11;
  localparam int AL_REF_LOST = 0;
  localparam int AL_INPUT_LOST_LSB = 1;
  localparam int AL_FREQ_OFFSET_LSB = 5;
  localparam int AL_UNLOCKED = 9;
  localparam int AL_HOLD_VALID = 10;
  localparam logic [ALARM_W-1:0] ALARM_RESET = 11'h000;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int SYNC_STAGES = 2;
  localparam int SOURCE_TO_IMAGE_CYCLES = SYNC_STAGES + 1;
  localparam logic [1:0] WARMUP_DONE = 2'h3;

  typedef logic [ALARM_W-1:0] alarm_vec_t;
  typedef logic [7:0] status_byte_t;

endpackage

// *** src/alarm_sync_if.sv ***
`timescale 1ns/1ps
interface alarm_sync_if;
  import alarm_status_pkg::*;
  alarm_vec_t raw;
  alarm_vec_t synced;
  modport sync_side (input raw, output synced);
  modport user_side (output raw, input synced);
endinterface

// *** src/alarm_sync.sv ***
`timescale 1ns/1ps
module alarm_sync
  import alarm_status_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n_sync,
  // Alarm levels
  alarm_sync_if.sync_side alarms
);

  // ------------------------------------------------------------
  // Two-stage level synchroniser; first stage feeds only the second
  // ------------------------------------------------------------
  alarm_vec_t stage_meta;
  alarm_vec_t stage_out;

  always_ff @(posedge clk_sys or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      stage_meta <= ALARM_RESET;
      stage_out <= ALARM_RESET;
    end else begin
      stage_meta <= alarms.raw;
      stage_out <= stage_meta;
    end
  end

  assign alarms.synced = stage_out;

endmodule

// *** tb/test_clock_alarm_live_status.sv ***
`timescale 1ns/1ps
module test_clock_alarm_live_status;
  import alarm_status_pkg::*;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [10:0] stim = 11'h000;
  logic [7:0] reg_addr = 8'h00;
  logic reg_rd_en = 1'b0;
  logic reg_wr_en = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  status_byte_t reg_rdata;
  status_byte_t input_loss_status;
  status_byte_t freq_lock_hold_status;
  logic reg_rd_valid;
  int fail_count = 0;
  int cmp_count = 0;
  logic [10:0] hist[$];
  logic [10:0] v;

  always #(CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;

  clock_alarm_live_status uut (
    .clk_sys(clk_sys), .reset_n(reset_n),
    .input1_signal_lost(stim[1]), .input2_signal_lost(stim[2]),
    .input3_signal_lost(stim[3]), .input4_signal_lost(stim[4]),
    .reference_signal_lost(stim[0]),
    .input1_freq_offset(stim[5]), .input2_freq_offset(stim[6]),
    .input3_freq_offset(stim[7]), .input4_freq_offset(stim[8]),
    .pll_unlocked(stim[9]), .hold_filter_valid(stim[10]),
    .reg_addr(reg_addr), .reg_rd_en(reg_rd_en), .reg_wr_en(reg_wr_en),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
    .input_loss_status(input_loss_status), .freq_lock_hold_status(freq_lock_hold_status)
  );

  // ----------------------------------------
  // Expected images from the stimulus vector
  // ----------------------------------------
  function automatic status_byte_t exp_loss(input logic [10:0] s);
    return {3'h0, s[4:1], s[0]};
  endfunction

  function automatic status_byte_t exp_freq(input logic [10:0] s);
    return {1'b0, s[10], 1'b0, s[8:5], s[9]};
  endfunction

  task automatic check(input string name, input status_byte_t seen, input status_byte_t exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic final_report;
    if (fail_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Register port and stimulus tasks
  // ----------------------------------------
  task automatic do_read(input logic [7:0] addr, input status_byte_t exp);
    @(posedge clk_sys);
    reg_addr <= addr;
    reg_rd_en <= 1'b1;
    reg_wr_en <= 1'($urandom);
    reg_wdata <= 8'($urandom);
    @(posedge clk_sys);
    reg_rd_en <= 1'b0;
    reg_wr_en <= 1'b0;
    @(negedge clk_sys);
    check("rd_valid", {7'h00, reg_rd_valid}, 8'h01);
    check("rdata", reg_rdata, exp);
    @(negedge clk_sys);
    check("rd_valid_drop", {7'h00, reg_rd_valid}, 8'h00);
    check("rdata_hold", reg_rdata, exp);
  endtask

  task automatic read_all(input logic [10:0] s);
    logic [7:0] u;
    @(posedge clk_sys);
    stim <= s;
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    check("loss_image", input_loss_status, exp_loss(s));
    check("freq_image", freq_lock_hold_status, exp_freq(s));
    do_read(ADDR_INPUT_LOSS, exp_loss(s));
    do_read(ADDR_FREQ_LOCK, exp_freq(s));
    u = 8'($urandom);
    if (u == ADDR_INPUT_LOSS || u == ADDR_FREQ_LOCK) begin
      u = u ^ 8'h10;
    end
    do_read(u, UNMAPPED_READ);
  endtask

  // Two reads taken on consecutive edges, strobe held high
  task automatic read_pair(input logic [10:0] s);
    read_all(s);
    @(posedge clk_sys);
    reg_addr <= ADDR_INPUT_LOSS;
    reg_rd_en <= 1'b1;
    @(posedge clk_sys);
    reg_addr <= ADDR_FREQ_LOCK;
    @(negedge clk_sys);
    check("pair_valid_a", {7'h00, reg_rd_valid}, 8'h01);
    check("pair_loss", reg_rdata, exp_loss(s));
    @(posedge clk_sys);
    reg_rd_en <= 1'b0;
    @(negedge clk_sys);
    check("pair_valid_b", {7'h00, reg_rd_valid}, 8'h01);
    check("pair_freq", reg_rdata, exp_freq(s));
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    final_report();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'hD518B7C2));
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (5) @(posedge clk_sys);
    read_all(11'h000);
    read_all(11'h7FF);
    for (int i = 0; i < 11; i++) begin
      read_all(11'h001 << i);
    end
    do_read(8'h80, UNMAPPED_READ);
    do_read(8'h83, UNMAPPED_READ);
    read_pair(11'h7FF);
    for (int i = 0; i < 8; i++) begin
      read_pair(11'($urandom));
    end
    for (int i = 0; i < 20; i++) begin
      read_all(11'($urandom));
    end
    // Writes alone give no answer and change nothing
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_sys);
      reg_addr <= i ? ADDR_FREQ_LOCK : ADDR_INPUT_LOSS;
      reg_wr_en <= 1'b1;
      reg_wdata <= 8'hFF;
      @(posedge clk_sys);
      reg_wr_en <= 1'b0;
      @(negedge clk_sys);
      check("wr_no_valid", {7'h00, reg_rd_valid}, 8'h00);
      check("wr_rdata", reg_rdata, UNMAPPED_READ);
      check("wr_loss", input_loss_status, exp_loss(stim));
      check("wr_freq", freq_lock_hold_status, exp_freq(stim));
    end
    // Inputs change every cycle; images follow three edges late
    hist.delete();
    for (int i = 0; i < 300; i++) begin
      @(posedge clk_sys);
      v = 11'($urandom);
      stim <= v;
      hist.push_back(v);
      @(negedge clk_sys);
      if (hist.size() == 4) begin
        check("live_loss", input_loss_status, exp_loss(hist[0]));
        check("live_freq", freq_lock_hold_status, exp_freq(hist[0]));
        void'(hist.pop_front());
      end
    end
    // Reset in mid-run clears the images at once
    read_all(11'h7FF);
    @(posedge clk_sys);
    reset_n <= 1'b0;
    @(negedge clk_sys);
    check("rst_loss", input_loss_status, STATUS_RESET);
    check("rst_freq", freq_lock_hold_status, STATUS_RESET);
    @(posedge clk_sys);
    reset_n <= 1'b1;
    read_all(11'h7FF);
    final_report();
  end
endmodule
